//--- design/pts_sched.sv
// Purpose: decides when one transmit object is sent and one receive object applied
// Assumes: frame layer delivers sync, remote request and receive strobes on clk_i
// Notes: timers count in ticks of the divider; zero disables a timer
`default_nettype none
`include "pts_map.svh"
module pts_sched
   import pts_pkg::*;
#(
   parameter int unsigned DATA_W = 64,
   parameter int unsigned TICK_CYCLES = `PTS_TICK_CYCLES
)(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // parameter write port
   input wire logic cfg_wr_i,
   input wire logic cfg_tx_i,
   input wire logic [7:0] cfg_sub_i,
   input wire logic [31:0] cfg_data_i,
   // bus events from frame layer
   input wire logic sync_i,
   input wire logic rtr_i,
   input wire logic rx_valid_i,
   input wire logic [DATA_W-1:0] rx_data_i,
   // application side
   input wire logic [DATA_W-1:0] app_in_i,
   input wire logic app_evt_i,
   input wire logic [15:0] sync_window_i,
   // transmit request to frame layer
   output logic tx_req_o,
   output logic [DATA_W-1:0] tx_data_o,
   output logic [10:0] tx_id_o,
   // receive result and status
   output logic [DATA_W-1:0] rx_out_o,
   output logic rx_apply_o,
   output logic rtr_fwd_o,
   output logic sync_smp_o,
   output logic err_o,
   output logic cfg_rej_o,
   output logic [7:0] tx_ttype_o
);
   typedef struct packed {
      logic [31:0] tx_cobid;
      logic [31:0] rx_cobid;
      logic [7:0] tx_tt;
      logic [7:0] rx_tt;
      logic [15:0] inhibit;
      logic [15:0] evtimer;
      logic [15:0] rx_wdog;
      logic [15:0] inh_cnt;
      logic [15:0] evt_cnt;
      logic [15:0] wdog_cnt;
      logic [15:0] sync_cnt;
      logic [7:0] nsync;
      logic [DATA_W-1:0] last_in;
      logic [DATA_W-1:0] smp;
      logic [DATA_W-1:0] rx_hold;
      logic rx_pend;
      logic tx_pend;
      logic tx_req;
      logic [DATA_W-1:0] tx_data;
      logic [DATA_W-1:0] rx_out;
      logic rx_apply;
      logic rtr_fwd;
      logic sync_smp;
      logic err;
      logic cfg_rej;
   } pts_sched_s;
   pts_sched_s st_reg;
   pts_sched_s st_next;
   logic tick;
   pts_mode_e tx_mode;
   pts_mode_e rx_mode;
   pts_mode_e wr_mode;
   logic wr_rsv;
   logic tx_rsv;
   logic rx_rsv;
   logic changed;
   logic send_want;
   logic inh_busy;
   // timer tick divider
   pts_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_o(tick)
   );
   // decode of stored and written types
   pts_ttype_dec u_dec_tx (
      .ttype_i(st_reg.tx_tt),
      .mode_o(tx_mode),
      .reserved_o(tx_rsv)
   );
   pts_ttype_dec u_dec_rx (
      .ttype_i(st_reg.rx_tt),
      .mode_o(rx_mode),
      .reserved_o(rx_rsv)
   );
   pts_ttype_dec u_dec_wr (
      .ttype_i(cfg_data_i[7:0]),
      .mode_o(wr_mode),
      .reserved_o(wr_rsv)
   );
   // count helper: ticks down to zero, holds at zero
   function automatic logic [15:0] dec_tick(input logic [15:0] v, input logic t);
      if (t && v != 16'h0000)
         return v - 16'h0001;
      return v;
   endfunction
   // timer load: one extra tick for values 1 to FFFE, since the first tick may follow the load at once
   function automatic logic [15:0] arm_ticks(input logic [15:0] v);
      if (v == 16'h0000 || v == 16'hFFFF)
         return v;
      return v + 16'h0001;
   endfunction
   assign changed = (app_in_i != st_reg.last_in) || app_evt_i;
   assign inh_busy = (st_reg.inhibit != 16'h0000) && (st_reg.inh_cnt != 16'h0000);
   // next state
   always_comb
   begin
      st_next = st_reg;
      st_next.tx_req = 1'b0;
      st_next.rx_apply = 1'b0;
      st_next.rtr_fwd = 1'b0;
      st_next.sync_smp = 1'b0;
      st_next.cfg_rej = 1'b0;
      send_want = 1'b0;
      st_next.last_in = app_in_i;
      st_next.inh_cnt = dec_tick(st_reg.inh_cnt, tick);
      st_next.evt_cnt = dec_tick(st_reg.evt_cnt, tick);
      st_next.wdog_cnt = dec_tick(st_reg.wdog_cnt, tick);
      st_next.sync_cnt = dec_tick(st_reg.sync_cnt, tick);
      // parameter writes
      if (cfg_wr_i)
      begin
         unique case (cfg_sub_i)
            `PTS_SUB_COBID:
               if (cfg_tx_i)
                  st_next.tx_cobid = cfg_data_i;
               else
                  st_next.rx_cobid = cfg_data_i;
            `PTS_SUB_TTYPE:
               if (wr_rsv)
                  st_next.cfg_rej = 1'b1;
               else if (cfg_tx_i)
                  st_next.tx_tt = cfg_data_i[7:0];
               else
                  st_next.rx_tt = cfg_data_i[7:0];
            `PTS_SUB_INHIBIT:
               if (cfg_tx_i)
                  st_next.inhibit = cfg_data_i[15:0];
            `PTS_SUB_EVTIMER:
               if (cfg_tx_i)
                  st_next.evtimer = cfg_data_i[15:0];
               else
                  st_next.rx_wdog = cfg_data_i[15:0];
            default:
               st_next.cfg_rej = 1'b1;
         endcase
      end
      // transmit side
      if (!st_reg.tx_cobid[`PTS_COBID_INVALID_BIT])
      begin
         unique case (tx_mode)
            PTS_ACYC_SYNC:
               if (sync_i)
               begin
                  st_next.smp = app_in_i;
                  send_want = changed || (app_in_i != st_reg.smp); // change since last sync
               end
            PTS_CYC_SYNC:
               if (sync_i)
               begin
                  st_next.smp = app_in_i;
                  if (st_reg.nsync + 8'h01 >= st_reg.tx_tt)
                  begin
                     st_next.nsync = 8'h00;
                     send_want = 1'b1;
                  end
                  else
                     st_next.nsync = st_reg.nsync + 8'h01;
               end
            PTS_SYNC_RTR:
            begin
               if (sync_i)
                  st_next.smp = app_in_i;
               send_want = rtr_i;
            end
            PTS_ASYNC_RTR:
            begin
               st_next.smp = app_in_i;
               send_want = rtr_i;
            end
            PTS_ASYNC_EVT:
            begin
               st_next.smp = app_in_i;
               send_want = changed;
               if (st_reg.evtimer != 16'h0000 && st_reg.evt_cnt == 16'h0000)
                  send_want = 1'b1;
            end
            PTS_RESERVED:
               send_want = 1'b0;
         endcase
         // remote requests go to the application in every mode
         if (rtr_i)
            st_next.rtr_fwd = 1'b1;
         // inhibit spacing; sends at once unless inhibit time runs, then waits in tx_pend
         if ((send_want || st_reg.tx_pend) && !inh_busy)
         begin
            st_next.tx_req = 1'b1;
            st_next.tx_pend = 1'b0;
            st_next.tx_data = (tx_mode == PTS_ASYNC_EVT || tx_mode == PTS_ASYNC_RTR) ?
                              app_in_i : st_next.smp;
            st_next.inh_cnt = arm_ticks(st_reg.inhibit);
            st_next.evt_cnt = st_reg.evtimer;
         end
         else if (send_want)
            st_next.tx_pend = 1'b1;
      end
      else
         st_next.tx_pend = 1'b0;
      // sync frame samples inputs and applies outputs
      if (sync_i)
      begin
         st_next.sync_smp = 1'b1;
         st_next.sync_cnt = arm_ticks(sync_window_i);
         if (st_reg.rx_pend)
         begin
            st_next.rx_out = st_reg.rx_hold;
            st_next.rx_apply = 1'b1;
            st_next.rx_pend = 1'b0;
         end
      end
      // receive side
      if (rx_valid_i && !st_reg.rx_cobid[`PTS_COBID_INVALID_BIT])
      begin
         st_next.wdog_cnt = arm_ticks(st_reg.rx_wdog);
         if (rx_mode == PTS_ACYC_SYNC || rx_mode == PTS_CYC_SYNC)
         begin
            st_next.rx_hold = rx_data_i;
            st_next.rx_pend = 1'b1;
         end
         else
         begin
            st_next.rx_out = rx_data_i;
            st_next.rx_apply = 1'b1;
         end
      end
      // watchdog and sync monitor set the error state
      if (st_reg.rx_wdog != 16'h0000 && st_reg.wdog_cnt == 16'h0001 && tick)
         st_next.err = 1'b1;
      if (sync_window_i != 16'h0000 && st_reg.sync_cnt == 16'h0001 && tick && !sync_i)
         st_next.err = 1'b1;
      if (st_next.err)
         st_next.rx_out = '0;
   end
   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg <= '0;
         st_reg.tx_tt <= `PTS_TT_RESET;
         st_reg.rx_tt <= `PTS_TT_RESET;
      end
      else
         st_reg <= st_next;
   end
   // outputs straight from the state
   assign tx_req_o = st_reg.tx_req;
   assign tx_data_o = st_reg.tx_data;
   assign tx_id_o = st_reg.tx_cobid[`PTS_COBID_ID_MSB:0];
   assign rx_out_o = st_reg.rx_out;
   assign rx_apply_o = st_reg.rx_apply;
   assign rtr_fwd_o = st_reg.rtr_fwd;
   assign sync_smp_o = st_reg.sync_smp;
   assign err_o = st_reg.err;
   assign cfg_rej_o = st_reg.cfg_rej;
   assign tx_ttype_o = st_reg.tx_tt;
   // assertions
   a_reserved_refused: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_wr_i && cfg_sub_i == `PTS_SUB_TTYPE && cfg_data_i[7:0] >= `PTS_TT_RSV_MIN
      && cfg_data_i[7:0] <= `PTS_TT_RSV_MAX |=> cfg_rej_o && $stable(tx_ttype_o))
      else $error("reserved type accepted");
   a_sync_apply: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_apply_o && (rx_mode == PTS_ACYC_SYNC || rx_mode == PTS_CYC_SYNC)
      && !$past(rx_valid_i) |-> $past(sync_i))
      else $error("sync rx applied without sync");
   a_sync_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      sync_i |=> sync_smp_o)
      else $error("sync sample missing");
   a_rtr_fwd: assert property (@(posedge clk_i) disable iff (rst_i)
      rtr_i && !st_reg.tx_cobid[31] |=> rtr_fwd_o)
      else $error("remote request not forwarded");
   a_inhibit_gap: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_req_o && st_reg.inhibit != 16'h0000 |=> !tx_req_o [*2])
      else $error("inhibit spacing broken");
   a_rtr_only: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_req_o && $past(tx_mode) == PTS_SYNC_RTR && $past(st_reg.inhibit) == 16'h0000
      |-> $past(rtr_i))
      else $error("type 252 sent without request");
   a_event_send: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_mode == PTS_ASYNC_EVT && changed && !st_reg.tx_cobid[31] && !inh_busy
      && !cfg_wr_i |=> tx_req_o)
      else $error("event not sent");
   a_disabled_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      st_reg.tx_cobid[31] && $past(st_reg.tx_cobid[31]) |-> !st_reg.tx_pend)
      else $error("disabled object pending");
   a_wdog_err: assert property (@(posedge clk_i) disable iff (rst_i)
      st_reg.rx_wdog != 16'h0000 && st_reg.wdog_cnt == 16'h0001 && tick |=> err_o)
      else $error("watchdog did not set error");
   a_stored_legal: assert property (@(posedge clk_i) disable iff (rst_i)
      !tx_rsv && !rx_rsv)
      else $error("reserved type stored");
   a_acyc_sync: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_req_o && $past(tx_mode) == PTS_ACYC_SYNC && $past(st_reg.inhibit) == 16'h0000
      |-> $past(sync_i))
      else $error("type 0 sent without sync");
   a_err_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
      err_o |=> err_o)
      else $error("error state left without reset");
endmodule
`default_nettype wire

//--- pkg/pts_map.svh
// Purpose: offsets, fields and reset values of the transmit object scheduler
// Assumes: 125 MHz clock, timers counted in 100 us ticks
// Notes: included by the design files
`ifndef PTS_MAP_SVH
`define PTS_MAP_SVH
`define PTS_RX_COMM_BASE 16'h1400
`define PTS_TX_COMM_BASE 16'h1800
`define PTS_SUB_COBID 8'h01
`define PTS_SUB_TTYPE 8'h02
`define PTS_SUB_INHIBIT 8'h03
`define PTS_SUB_EVTIMER 8'h05
`define PTS_COBID_INVALID_BIT 31
`define PTS_COBID_ID_MSB 10
`define PTS_TT_ACYC_SYNC 8'h00
`define PTS_TT_CYC_MAX 8'hF0
`define PTS_TT_RSV_MIN 8'hF1
`define PTS_TT_RSV_MAX 8'hFB
`define PTS_TT_SYNC_RTR 8'hFC
`define PTS_TT_ASYNC_RTR 8'hFD
`define PTS_TT_ASYNC_MFR 8'hFE
`define PTS_TT_ASYNC_PRO 8'hFF
`define PTS_TT_RESET 8'hFF
`define PTS_TICK_US 100
`define PTS_CLK_MHZ 125
`define PTS_TICK_CYCLES (`PTS_TICK_US * `PTS_CLK_MHZ)
`endif

//--- pkg/pts_pkg.sv
// Purpose: types of the transmit object scheduler
// Assumes: constants come from pts_map.svh
// Notes: decode of the transmission type
`default_nettype none
package pts_pkg;
   typedef enum logic [2:0] {
      PTS_ACYC_SYNC,
      PTS_CYC_SYNC,
      PTS_RESERVED,
      PTS_SYNC_RTR,
      PTS_ASYNC_RTR,
      PTS_ASYNC_EVT
   } pts_mode_e;
endpackage
`default_nettype wire

//--- design/pts_tick.sv
// Purpose: divider giving a one-cycle timer tick
// Assumes: single clock, synchronous reset
// Notes: tick period is a parameter so simulation can shorten it
`default_nettype none
`include "pts_map.svh"
module pts_tick
   import pts_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `PTS_TICK_CYCLES
)(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // tick out
   output logic tick_o
);
   typedef struct packed {
      logic [23:0] cnt;
      logic tick;
   } pts_tick_s;
   pts_tick_s st_reg;
   pts_tick_s st_next;
   // count down and pulse at wrap
   always_comb
   begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (st_reg.cnt == 24'h000000)
      begin
         st_next.cnt = 24'(TICK_CYCLES - 1);
         st_next.tick = 1'b1;
      end
      else
      begin
         st_next.cnt = st_reg.cnt - 24'h000001;
      end
   end
   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
   assign tick_o = st_reg.tick;
endmodule
`default_nettype wire

//--- design/pts_ttype_dec.sv
// Purpose: decode of an 8-bit transmission type into a mode
// Assumes: combinational, same clock domain as user
// Notes: reserved codes flagged so writes can be refused
`default_nettype none
`include "pts_map.svh"
module pts_ttype_dec
   import pts_pkg::*;
(
   // type in
   input wire logic [7:0] ttype_i,
   // decoded mode
   output pts_mode_e mode_o,
   output logic reserved_o
);
   // map type codes onto modes
   always_comb
   begin
      if (ttype_i == `PTS_TT_ACYC_SYNC)
         mode_o = PTS_ACYC_SYNC;
      else if (ttype_i <= `PTS_TT_CYC_MAX)
         mode_o = PTS_CYC_SYNC;
      else if (ttype_i <= `PTS_TT_RSV_MAX)
         mode_o = PTS_RESERVED;
      else if (ttype_i == `PTS_TT_SYNC_RTR)
         mode_o = PTS_SYNC_RTR;
      else if (ttype_i == `PTS_TT_ASYNC_RTR)
         mode_o = PTS_ASYNC_RTR;
      else
         mode_o = PTS_ASYNC_EVT;
      reserved_o = (mode_o == PTS_RESERVED);
   end
endmodule
`default_nettype wire

//--- verif/pts_far_end.sv
// Purpose: frame-layer far side sending sync, remote request and rx frames
// Assumes: strobes change on the falling edge of clk_i
// Notes: payload is inverted after each frame so stale data never passes
`default_nettype none
module pts_far_end #(
   parameter int unsigned DATA_W = 64
)(
   // clock
   input wire logic clk_i,
   // frames toward the scheduler
   output logic sync_o,
   output logic rtr_o,
   output logic rx_valid_o,
   output logic [DATA_W-1:0] rx_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus
   initial
   begin
      sync_o = 1'b0;
      rtr_o = 1'b0;
      rx_valid_o = 1'b0;
      rx_data_o = '0;
   end
   // one frame strobe: 0 sync, 1 remote request, 2 rx object
   task automatic frame(input int kind, input logic [DATA_W-1:0] word);
      @(negedge clk_i);
      sync_o = (kind == 0);
      rtr_o = (kind == 1);
      rx_valid_o = (kind == 2);
      if (kind == 2)
      begin
         rx_data_o = word;
      end
      @(negedge clk_i);
      sync_o = 1'b0;
      rtr_o = 1'b0;
      rx_valid_o = 1'b0;
      rx_data_o = ~rx_data_o; // payload only means something with its strobe
   endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: self-checking bench of the transmit object scheduler
// Assumes: tick shortened to 4 cycles, inputs change on falling edge
// Notes: pulse outputs are counted on the rising edge
`default_nettype none
`define CHK(nm, e, s) \
   begin \
      checks++; \
      if ((s) !== (e)) \
      begin \
         err_total++; \
         $display("MISMATCH %s exp %0h got %0h", nm, e, s); \
      end \
   end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic tx; logic [7:0] sub; logic [31:0] d; int rej; logic [7:0] tt;} pts_row_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cfg_wr = 1'b0;
   logic cfg_tx = 1'b0;
   logic [7:0] cfg_sub = 8'h00;
   logic [31:0] cfg_data = 32'h0;
   logic [63:0] app_in = '0;
   logic [15:0] sync_window = 16'h0;
   logic app_evt = 1'b0;
   logic sync, rtr, rx_valid, tx_req, rx_apply, rtr_fwd, sync_smp, err, cfg_rej;
   logic [63:0] rx_data, tx_data, rx_out, last_tx;
   logic [10:0] tx_id;
   logic [7:0] tx_ttype;
   int cnt[5];
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   pts_row_s rows[10] = '{'{1, 8'h02, 32'hF1, 1, 8'hFF}, '{1, 8'h02, 32'hFB, 1, 8'hFF},
      '{1, 8'h02, 32'h00, 0, 8'h00}, '{1, 8'h02, 32'hF0, 0, 8'hF0},
      '{1, 8'h02, 32'hFC, 0, 8'hFC}, '{1, 8'h02, 32'hFD, 0, 8'hFD},
      '{1, 8'h02, 32'hFE, 0, 8'hFE}, '{1, 8'h02, 32'hFF, 0, 8'hFF},
      '{1, 8'h04, 32'h00, 1, 8'hFF}, '{0, 8'h02, 32'hF5, 1, 8'hFF}};
   // 125 MHz clock
   always #4 clk = ~clk;
   pts_far_end pts_far_end_i (.clk_i(clk), .sync_o(sync), .rtr_o(rtr), .rx_valid_o(rx_valid),
      .rx_data_o(rx_data));
   pts_sched #(.TICK_CYCLES(4)) pts_sched_i (.clk_i(clk), .rst_i(rst), .cfg_wr_i(cfg_wr),
      .cfg_tx_i(cfg_tx), .cfg_sub_i(cfg_sub), .cfg_data_i(cfg_data), .sync_i(sync),
      .rtr_i(rtr), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .app_in_i(app_in),
      .app_evt_i(app_evt), .sync_window_i(sync_window), .tx_req_o(tx_req),
      .tx_data_o(tx_data), .tx_id_o(tx_id), .rx_out_o(rx_out), .rx_apply_o(rx_apply),
      .rtr_fwd_o(rtr_fwd), .sync_smp_o(sync_smp), .err_o(err), .cfg_rej_o(cfg_rej),
      .tx_ttype_o(tx_ttype));
   // count pulses seen before each rising edge, and cut a hang short
   always @(posedge clk)
   begin
      cyc++;
      if (tx_req === 1'b1)
      begin
         cnt[0]++;
         last_tx = tx_data;
      end
      cnt[1] += (rtr_fwd === 1'b1);
      cnt[2] += (sync_smp === 1'b1);
      cnt[3] += (rx_apply === 1'b1);
      cnt[4] += (cfg_rej === 1'b1);
      if (cyc == 4000)
      begin
         err_total++;
         end_of_test();
      end
   end
   task automatic end_of_test;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
      begin
         $display("Test passed");
      end
      else
      begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic clr;
      cnt = '{default: 0};
   endtask
   task automatic cfg(input logic tx, input logic [7:0] sub, input logic [31:0] d);
      @(negedge clk);
      cfg_wr = 1'b1;
      cfg_tx = tx;
      cfg_sub = sub;
      cfg_data = d;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask
   task automatic do_reset;
      app_in = '0;
      rst = 1'b1;
      idle(16);
      rst = 1'b0;
      idle(1);
      clr();
   endtask
   // main sequence
   initial
   begin
      do_reset();
      `CHK("ttype", 8'hFF, tx_ttype)
      `CHK("err", 1'b0, err)
      `CHK("rx_out", 64'h0, rx_out)
      foreach (rows[i])
      begin
         clr();
         cfg(rows[i].tx, rows[i].sub, rows[i].d);
         idle(2);
         `CHK("rej", rows[i].rej, cnt[4])
         `CHK("ttype", rows[i].tt, tx_ttype)
      end
      clr();
      app_in = 64'h1111_2222_3333_4444;
      idle(4);
      `CHK("tx255", 1, cnt[0])
      `CHK("txd", 64'h1111_2222_3333_4444, last_tx)
      // an application event with no input change also sends
      app_evt = 1'b1;
      idle(1);
      app_evt = 1'b0;
      idle(3);
      `CHK("txev", 2, cnt[0])
      cfg(1, 8'h01, 32'h0000_0123);
      app_in = 64'h5;
      idle(4);
      `CHK("id", 11'h123, tx_id)
      cfg(1, 8'h01, 32'h8000_0123);
      clr();
      app_in = 64'h6;
      idle(4);
      `CHK("off", 0, cnt[0])
      // inhibit: 5 ticks of 4 cycles
      do_reset();
      cfg(1, 8'h03, 32'h5);
      app_in = 64'hA;
      idle(3);
      `CHK("inh1", 1, cnt[0])
      app_in = 64'hB;
      idle(6);
      `CHK("inh2", 1, cnt[0])
      idle(30);
      `CHK("inh3", 2, cnt[0])
      `CHK("inhd", 64'hB, last_tx)
      // let the deferred send's own inhibit time run out first
      idle(20);
      app_in = 64'hC;
      idle(3);
      `CHK("inh4", 3, cnt[0])
      // event timer of 3 ticks, then off
      do_reset();
      cfg(1, 8'h05, 32'h3);
      clr();
      idle(40);
      `CHK("evt", 1'b1, cnt[0] inside {[2:4]})
      cfg(1, 8'h05, 32'h0);
      idle(3);
      clr();
      idle(40);
      `CHK("evt0", 0, cnt[0])
      // cyclic every 3rd sync
      do_reset();
      cfg(1, 8'h02, 32'h3);
      app_in = 64'h7;
      clr();
      repeat (6) pts_far_end_i.frame(0, '0);
      idle(3);
      `CHK("cyc", 2, cnt[0])
      `CHK("smp", 6, cnt[2])
      // acyclic synchronous transmit
      cfg(1, 8'h02, 32'h0);
      clr();
      app_in = 64'h8;
      idle(4);
      `CHK("t0a", 0, cnt[0])
      pts_far_end_i.frame(0, '0);
      pts_far_end_i.frame(0, '0);
      idle(3);
      `CHK("t0b", 1, cnt[0])
      `CHK("t0d", 64'h8, last_tx)
      // remote request only types
      cfg(1, 8'h02, 32'hFC);
      app_in = 64'hD1;
      pts_far_end_i.frame(0, '0);
      app_in = 64'hD2;
      idle(2);
      clr();
      pts_far_end_i.frame(1, '0);
      idle(3);
      `CHK("rtrf", 1, cnt[1])
      `CHK("252n", 1, cnt[0])
      `CHK("252d", 64'hD1, last_tx)
      cfg(1, 8'h02, 32'hFD);
      app_in = 64'hD3;
      idle(2);
      `CHK("253q", 1, cnt[0])
      pts_far_end_i.frame(1, '0);
      idle(3);
      `CHK("253d", 64'hD3, last_tx)
      // receive objects: asynchronous type applies at once, types 0 to 240 wait for sync
      do_reset();
      pts_far_end_i.frame(2, 64'h77);
      idle(2);
      `CHK("rxa", 64'h77, rx_out)
      cfg(0, 8'h02, 32'h0);
      clr();
      pts_far_end_i.frame(2, 64'hCAFE);
      idle(5);
      `CHK("rx0", 0, cnt[3])
      `CHK("rx0d", 64'h77, rx_out)
      pts_far_end_i.frame(0, '0);
      idle(3);
      `CHK("rx1", 1, cnt[3])
      `CHK("rx1d", 64'hCAFE, rx_out)
      cfg(0, 8'h02, 32'h5);
      pts_far_end_i.frame(2, 64'hBEEF);
      pts_far_end_i.frame(0, '0);
      idle(3);
      `CHK("rx5d", 64'hBEEF, rx_out)
      // receive watchdog of 2 ticks, armed by a received object
      cfg(0, 8'h05, 32'h2);
      pts_far_end_i.frame(2, 64'h1234);
      idle(2);
      `CHK("wdq", 1'b0, err)
      idle(20);
      `CHK("wdog", 1'b1, err)
      `CHK("wdz", 64'h0, rx_out)
      do_reset();
      `CHK("err0", 1'b0, err)
      // missing sync
      sync_window = 16'h2;
      do_reset();
      pts_far_end_i.frame(0, '0);
      idle(20);
      `CHK("syncw", 1'b1, err)
      end_of_test();
   end
endmodule
`default_nettype wire
